// ### pkg/gpb_pkg.sv
package gpb_pkg;

	// ****************************************
	// widths and address spaces
	// ****************************************
	localparam int unsigned PORT_WIDTH = 8;
	localparam int unsigned ADDR_WIDTH = 16;
	localparam int unsigned NUM_PORTS  = 3;

	// short io window sits this far below the data-space address
	localparam logic [15:0] IO_SPACE_OFFSET  = 16'h0020;
	localparam logic [15:0] IO_SPACE_LAST    = 16'h003f;
	localparam logic [15:0] EXT_IO_FIRST     = 16'h0060;

	// ****************************************
	// data-space offsets
	// ****************************************
	localparam logic [15:0] PORT_B_PIN_LEVELS_OFF   = 16'h0023;
	localparam logic [15:0] PORT_B_DIRECTION_OFF    = 16'h0024;
	localparam logic [15:0] PORT_B_OUTPUT_VALUE_OFF = 16'h0025;
	localparam logic [15:0] PORT_C_PIN_LEVELS_OFF   = 16'h0026;
	localparam logic [15:0] PORT_C_DIRECTION_OFF    = 16'h0027;
	localparam logic [15:0] PORT_C_OUTPUT_VALUE_OFF = 16'h0028;
	localparam logic [15:0] PORT_D_PIN_LEVELS_OFF   = 16'h0029;
	localparam logic [15:0] PORT_D_DIRECTION_OFF    = 16'h002a;
	localparam logic [15:0] PORT_D_OUTPUT_VALUE_OFF = 16'h002b;

	// registers of one port are three consecutive addresses
	localparam logic [15:0] PORT_STRIDE   = 16'h0003;
	localparam logic [15:0] PORT_BASE_OFF = PORT_B_PIN_LEVELS_OFF;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] DIRECTION_RST = 8'h00;
	localparam logic [7:0] OUTPUT_RST    = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// access kind on the core bus
	typedef enum logic [1:0] {
		GPB_ACC_IDLE = 2'b01,
		GPB_ACC_BUSY = 2'b10
	} gpb_acc_type;

endpackage

// ### rtl/gpb_ports.sv
`timescale 1ns/1ps
module gpb_ports (
	// clock and reset
	input  wire logic                  ref_clk_i,
	input  wire logic                  sys_rst_i,
	// core bus: one-cycle strobes, io_space_i selects the short io address map
	input  wire logic                  bus_rd_i,
	input  wire logic                  bus_wr_i,
	input  wire logic                  io_space_i,
	input  wire logic [15:0]           bus_addr_i,
	input  wire logic [7:0]            bus_wdata_i,
	output logic      [7:0]            bus_rdata_o,
	output logic                       bus_hit_o,
	// virtual-port direction alias: port select 0=b 1=c 2=d
	input  wire logic                  vdir_wr_i,
	input  wire logic [1:0]            vdir_sel_i,
	input  wire logic [7:0]            vdir_wdata_i,
	output logic      [7:0]            vdir_rdata_o,
	// pull-up control from the core
	input  wire logic                  global_pullup_disable_i,
	// pins, ports packed b in [7:0], c in [15:8], d in [23:16]
	input  wire logic [23:0]           pin_i,
	output logic      [23:0]           pin_o,
	output logic      [23:0]           pin_oe_n_o,
	output logic      [23:0]           pin_pullup_o
);
	import gpb_pkg::*;

	// ****************************************
	// geometry checks
	// ****************************************
	// pin packing and the three-way decode are written for three byte-wide ports;
	// other sizes would silently misalign the pins, so they are refused here
	if (PORT_WIDTH != 8) begin : g_bad_width
		$error("gpb_ports serves byte-wide ports only");
	end
	if (NUM_PORTS != 3) begin : g_bad_count
		$error("gpb_ports serves exactly three ports");
	end
	if (ADDR_WIDTH != 16) begin : g_bad_addr
		$error("gpb_ports decodes a 16-bit address only");
	end

	// ****************************************
	// state
	// ****************************************
	// one packed record holds every flip-flop of the block
	typedef struct packed {
		logic [2:0][7:0] output_value;
		logic [2:0][7:0] direction;
		logic [2:0][7:0] sync1;
		logic [2:0][7:0] sync2;
		logic [7:0]      rdata;
		logic            hit;
	} gpb_state_type;

	gpb_state_type state_q;
	gpb_state_type state_d;

	// decode results, all combinational
	logic [15:0] data_addr;
	logic        addr_ok;
	logic [15:0] rel;
	logic [1:0]  port_idx;
	logic [1:0]  reg_idx;

	// ****************************************
	// address decode
	// ****************************************
	// short io addresses are rebased into data space; data space reached past the io window
	// extended io from 0x60 up never matches, so it stays out of short io reach
	always_comb begin
		data_addr = bus_addr_i;
		addr_ok   = 1'b1;
		if (io_space_i) begin
			addr_ok   = (bus_addr_i <= IO_SPACE_LAST);
			data_addr = bus_addr_i + IO_SPACE_OFFSET;
		end
		rel      = data_addr - PORT_BASE_OFF;
		port_idx = 2'd0;
		reg_idx  = 2'd0;
		if (rel < 16'h0003) begin
			port_idx = 2'd0;
			reg_idx  = rel[1:0];
		end else if (rel < 16'h0006) begin
			port_idx = 2'd1;
			reg_idx  = 2'(rel - PORT_STRIDE);
		end else if (rel < 16'h0009) begin
			port_idx = 2'd2;
			reg_idx  = 2'(rel - 16'h0006);
		end else begin
			addr_ok = 1'b0;
		end
		// unsigned wrap below the base also lands here
		if (data_addr < PORT_BASE_OFF) begin
			addr_ok = 1'b0;
		end
	end

	// ****************************************
	// next state
	// ****************************************
	// reg_idx 0 = pin levels, 1 = direction, 2 = output value
	// later assignments win, so the order below sets the priority
	always_comb begin
		state_d       = state_q;
		// two-stage synchroniser; only the second stage feeds the read path
		state_d.sync1 = pin_i;
		state_d.sync2 = state_q.sync1;
		// hit answers the strobe of this cycle for one cycle only
		state_d.hit   = (bus_rd_i | bus_wr_i) & addr_ok;
		state_d.rdata = state_q.rdata;
		// read data is captured once and stands until the next read or reset
		if (bus_rd_i) begin
			state_d.rdata = UNMAPPED_READ;
			if (addr_ok) begin
				case (reg_idx)
					2'd0:    state_d.rdata = state_q.sync2[port_idx];
					2'd1:    state_d.rdata = state_q.direction[port_idx];
					2'd2:    state_d.rdata = state_q.output_value[port_idx];
					default: state_d.rdata = UNMAPPED_READ;
				endcase
			end
		end
		// stores; a pin-levels store flips output bits instead of landing anywhere
		if (bus_wr_i && addr_ok) begin
			case (reg_idx)
				2'd0:    state_d.output_value[port_idx] =
					state_q.output_value[port_idx] ^ bus_wdata_i;
				2'd1:    state_d.direction[port_idx] = bus_wdata_i;
				2'd2:    state_d.output_value[port_idx] = bus_wdata_i;
				default: state_d.hit = 1'b0;
			endcase
		end
		// alias written last so it wins a same-cycle clash with a bus store
		if (vdir_wr_i && vdir_sel_i < 2'd3) begin
			state_d.direction[vdir_sel_i] = vdir_wdata_i;
		end
		// synchronous reset; the synchroniser stages are left free on purpose
		if (sys_rst_i) begin
			state_d.output_value = {NUM_PORTS{OUTPUT_RST}};
			state_d.direction    = {NUM_PORTS{DIRECTION_RST}};
			state_d.rdata        = UNMAPPED_READ;
			state_d.hit          = 1'b0;
		end
	end

	// synchronisers are not reset; pin levels carry no reset value
	// so a pin read right after reset shows whatever the pads held
	always_ff @(posedge ref_clk_i) begin
		state_q <= state_d;
	end

	// ****************************************
	// outputs
	// ****************************************
	// registered bus answer
	assign bus_rdata_o  = state_q.rdata;
	assign bus_hit_o    = state_q.hit;
	// alias read returns the real direction register
	assign vdir_rdata_o = (vdir_sel_i < 2'd3) ? state_q.direction[vdir_sel_i] : UNMAPPED_READ;

	// per-pin driver and pull-up
	// pull-up follows the disable input directly, so it drops in the same cycle
	for (genvar g = 0; g < 24; g++) begin : g_pin
		assign pin_o[g]        = state_q.output_value[g/8][g%8];
		assign pin_oe_n_o[g]   = ~state_q.direction[g/8][g%8];
		assign pin_pullup_o[g] = ~state_q.direction[g/8][g%8] &
			state_q.output_value[g/8][g%8] & ~global_pullup_disable_i;
	end

	// ****************************************
	// checks
	// ****************************************
	// attempts are off while reset is high; the reset checks run without that guard
	// an access is one strobe cycle, its answer shows one clock later

	// bus decode and address maps
	a_io_rebase_dir: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(bus_wr_i && io_space_i && bus_addr_i == 16'h0004 && !vdir_wr_i)
		|=> state_q.direction[0] == $past(bus_wdata_i))
		else $error("short io write missed direction b");

	a_data_space_dir: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(bus_wr_i && !io_space_i && bus_addr_i == PORT_D_DIRECTION_OFF && !vdir_wr_i)
		|=> state_q.direction[2] == $past(bus_wdata_i))
		else $error("data space write missed direction d");

	a_io_no_ext: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(bus_wr_i && io_space_i && bus_addr_i >= 16'h0040) |=> !bus_hit_o)
		else $error("short io reached beyond its window");

	a_write_hit: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(bus_wr_i && !io_space_i && bus_addr_i == PORT_C_OUTPUT_VALUE_OFF)
		|=> bus_hit_o)
		else $error("data space write to output c not answered");

	a_io_out_d: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(bus_wr_i && io_space_i && bus_addr_i == PORT_D_OUTPUT_VALUE_OFF - IO_SPACE_OFFSET)
		|=> state_q.output_value[2] == $past(bus_wdata_i))
		else $error("short io write missed output d");

	a_io_read_c: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(bus_rd_i && io_space_i && bus_addr_i == PORT_C_DIRECTION_OFF - IO_SPACE_OFFSET)
		|=> bus_rdata_o == $past(state_q.direction[1]))
		else $error("short io read of direction c wrong");

	a_unmapped_read: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(bus_rd_i && !io_space_i && (bus_addr_i < PORT_B_PIN_LEVELS_OFF
			|| bus_addr_i > PORT_D_OUTPUT_VALUE_OFF))
		|=> (bus_rdata_o == UNMAPPED_READ && !bus_hit_o))
		else $error("unmapped read not refused");

	a_ext_no_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(bus_wr_i && io_space_i && bus_addr_i > IO_SPACE_LAST && !vdir_wr_i)
		|=> ($stable(state_q.direction) && $stable(state_q.output_value)))
		else $error("short io beyond window changed a register");

	a_hit_once: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		bus_hit_o |-> $past(bus_rd_i || bus_wr_i))
		else $error("hit without a strobe");

	// register contents
	a_reset_clears: assert property (@(posedge ref_clk_i)
		sys_rst_i |=> (state_q.direction == '0 && state_q.output_value == '0))
		else $error("registers not cleared by reset");

	a_out_reset_pins: assert property (@(posedge ref_clk_i)
		sys_rst_i |=> (pin_oe_n_o == '1 && pin_o == '0))
		else $error("pins not released by reset");

	a_pin_toggle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(bus_wr_i && !io_space_i && bus_addr_i == PORT_C_PIN_LEVELS_OFF)
		|=> state_q.output_value[1] == ($past(state_q.output_value[1]) ^ $past(bus_wdata_i)))
		else $error("pin write did not toggle port c");

	a_pin_no_store: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(bus_wr_i && !io_space_i && bus_addr_i == PORT_B_PIN_LEVELS_OFF && !vdir_wr_i)
		|=> $stable(state_q.direction))
		else $error("pin write changed a direction");

	a_rdata_holds: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!bus_rd_i |=> $stable(bus_rdata_o))
		else $error("read data moved without a read");

	a_vdir_alias: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(vdir_wr_i && vdir_sel_i == 2'd1) |=> state_q.direction[1] == $past(vdir_wdata_i))
		else $error("virtual direction write lost");

	a_vdir_wins: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(vdir_wr_i && vdir_sel_i == 2'd0 && bus_wr_i && !io_space_i
			&& bus_addr_i == PORT_B_DIRECTION_OFF)
		|=> state_q.direction[0] == $past(vdir_wdata_i))
		else $error("alias lost a same-cycle clash");

	a_vdir_none: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		vdir_sel_i == 2'd3 |-> vdir_rdata_o == UNMAPPED_READ)
		else $error("alias read with no port selected");

	// pins
	a_pin_read: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(bus_rd_i && !io_space_i && bus_addr_i == PORT_B_PIN_LEVELS_OFF)
		|=> bus_rdata_o == $past(pin_i[7:0], 3))
		else $error("pin read not the synchronised level");

	a_pin_read_d: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(bus_rd_i && io_space_i && bus_addr_i == PORT_D_PIN_LEVELS_OFF - IO_SPACE_OFFSET)
		|=> bus_rdata_o == $past(pin_i[23:16], 3))
		else $error("short io pin read of port d wrong");

	a_dir_drive: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(bus_wr_i && !io_space_i && bus_addr_i == PORT_B_DIRECTION_OFF && !vdir_wr_i)
		|=> pin_oe_n_o[7:0] == ~$past(bus_wdata_i))
		else $error("output enable not following direction");

	a_pullup_gate: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		global_pullup_disable_i |-> pin_pullup_o == '0)
		else $error("pull-up on while globally disabled");

	a_pullup_cross: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!global_pullup_disable_i |-> pin_pullup_o == (pin_oe_n_o & pin_o))
		else $error("pull-up not set by input with output one");

endmodule

// ### tb/gpb_pad_model.sv
`timescale 1ns/1ps
// ****************
// pads seen from the board side
// ****************
module gpb_pad_model (
	// what the port drives
	input  wire logic [23:0] drv_i,
	input  wire logic [23:0] oe_n_i,
	input  wire logic [23:0] pull_i,
	// outside drivers
	input  wire logic [23:0] ext_i,
	input  wire logic [23:0] ext_en_i,
	output logic      [23:0] lvl_o
);
	// own driver wins, then the outside one; a bare pad is high only with pull-up
	assign lvl_o = (~oe_n_i & drv_i) | (oe_n_i & ext_en_i & ext_i) | (oe_n_i & ~ext_en_i & pull_i);
endmodule

// ### tb/gpio_port_bcd_registers_bench.sv
`timescale 1ns/1ps
module gpio_port_bcd_registers_bench;
	import gpb_pkg::*;
	// ****************
	// stimulus and model state
	// ****************
	logic            clk = 0, rst = 1, rd = 0, wr = 0, io = 0, vw = 0, dis = 0;
	logic [15:0]     adr = '0;
	logic [7:0]      wd = '0, vwd = '0, rdat, vrd;
	logic [1:0]      vsel = 2'h3;
	logic [23:0]     lvl, po, oen, pu, ext = '0, een = '0;
	logic            hit;
	logic [2:0][7:0] dir, outv;
	int              fail_count = 0, n_tests = 0, seed = 32'h1228b173;

	gpb_ports i_gpb_ports (.ref_clk_i(clk), .sys_rst_i(rst), .bus_rd_i(rd), .bus_wr_i(wr),
		.io_space_i(io), .bus_addr_i(adr), .bus_wdata_i(wd), .bus_rdata_o(rdat),
		.bus_hit_o(hit), .vdir_wr_i(vw), .vdir_sel_i(vsel), .vdir_wdata_i(vwd),
		.vdir_rdata_o(vrd), .global_pullup_disable_i(dis), .pin_i(lvl), .pin_o(po),
		.pin_oe_n_o(oen), .pin_pullup_o(pu));
	gpb_pad_model i_gpb_pad_model (.drv_i(po), .oe_n_i(oen), .pull_i(pu), .ext_i(ext),
		.ext_en_i(een), .lvl_o(lvl));

	// 200 mhz clock
	initial begin
		forever #2.5 clk = ~clk;
	end

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// one strobe cycle; hit is looked at right after the taking edge
	task automatic acc(input logic w, input logic s, input logic [15:0] a,
			input logic [7:0] d, input logic h);
		@(posedge clk);
		wr <= w;
		rd <= ~w;
		io <= s;
		adr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 0;
		rd <= 0;
		#1 chk(hit, h);
	endtask

	// port p, kind k (0 pins, 1 direction, 2 output), short io map when s
	function automatic logic [15:0] ad(int p, int k, logic s);
		return 16'(PORT_BASE_OFF + PORT_STRIDE * 16'(p) + 16'(k) - (s ? IO_SPACE_OFFSET : 16'h0000));
	endfunction

	// pad levels the pin registers should show
	function automatic logic [23:0] exp_lvl();
		return (dir & outv) | (~dir & een & ext) | (~dir & ~een & outv & {24{~dis}});
	endfunction

	// a hung run still ends in the report
	initial begin
		#100000;
		fail_count++;
		conclude();
	end

	// reset, random traffic, alias and refused accesses
	initial begin
		int p, k;
		logic s;
		logic [7:0] v;
		dir = '0;
		outv = '0;
		repeat (4) @(posedge clk);
		rst <= 0;
		for (p = 0; p < 3; p++) begin
			for (k = 1; k < 3; k++) begin
				acc(0, p[0], ad(p, k, p[0]), 8'h00, 1);
				chk(rdat, 24'h0);
			end
		end
		chk(oen, 24'hffffff);
		for (int i = 0; i < 40; i++) begin
			p = {$random(seed)} % 3;
			k = {$random(seed)} % 3;
			s = 1'($random(seed));
			v = 8'($random(seed));
			// pads and pull-up disable move on a clock edge, settled before the write
			@(posedge clk);
			ext <= 24'($random(seed));
			een <= 24'($random(seed));
			dis <= 1'($random(seed));
			acc(1, s, ad(p, k, s), v, 1);
			if (k == 0)
				outv[p] = outv[p] ^ v;
			else if (k == 1)
				dir[p] = v;
			else
				outv[p] = v;
			chk(po, outv);
			chk(oen, ~dir);
			chk(pu, ~dir & outv & {24{~dis}});
			if (k != 0) begin
				acc(0, ~s, ad(p, k, ~s), 8'h00, 1);
				chk(rdat, k == 1 ? dir[p] : outv[p]);
			end
			repeat (3) @(posedge clk);
			acc(0, ~s, ad(p, 0, ~s), 8'h00, 1);
			chk(rdat, 8'(exp_lvl() >> (8 * p)));
		end
		for (int q = 0; q < 3; q++) begin
			v = 8'($random(seed));
			@(posedge clk);
			vsel <= 2'(q);
			vw <= 1;
			vwd <= v;
			@(posedge clk);
			vw <= 0;
			dir[q] = v;
			#1 chk(vrd, v);
			acc(0, 0, ad(q, 1, 0), 8'h00, 1);
			chk(rdat, v);
		end
		// alias and bus store on one edge: the alias value is kept
		@(posedge clk);
		vsel <= 2'd0;
		vw <= 1;
		vwd <= 8'h5a;
		wr <= 1;
		io <= 0;
		adr <= ad(0, 1, 0);
		wd <= 8'ha5;
		@(posedge clk);
		vw <= 0;
		wr <= 0;
		vsel <= 2'h3;
		dir[0] = 8'h5a;
		#1 chk(oen, ~dir);
		chk(vrd, UNMAPPED_READ);
		// short io past 0x3f and a gap address are both refused
		acc(1, 1, 16'h0044, 8'hff, 0);
		acc(0, 0, 16'h002c, 8'h00, 0);
		chk(rdat, UNMAPPED_READ);
		chk(oen, ~dir);
		conclude();
	end
endmodule
